// ==== verilog/supervisor_pkg.sv ====
// Package with timing counts, output styles and input flag bundle.
package supervisor_pkg;

    // Output style of the reset pin.
    typedef enum logic [1:0] {
        STYLE_HIGH_OD = 2'b00,
        STYLE_LOW_PP  = 2'b01,
        STYLE_LOW_OD  = 2'b10
    } reset_style_t;

    // Supply comparator results from the analog front end.
    typedef struct packed {
        logic main_ok;        // Main supply above supply_trip_level.
        logic aux_ok;         // Auxiliary monitor above its reference.
        logic backup_gt_main; // Backup exceeds main by the upper margin.
        logic main_gt_backup; // Main exceeds backup by the upper margin.
    } supply_flags_t;

    localparam int unsigned CLK_FREQ_HZ     = 100_000_000;
    localparam int unsigned HOLD_TIME_MS    = 150;
    localparam int unsigned WD_WINDOW_MS    = 1000;
    localparam longint unsigned HOLD_CYCLES =
        (longint'(HOLD_TIME_MS) * CLK_FREQ_HZ + 999) / 1000;
    localparam longint unsigned WD_CYCLES   =
        (longint'(WD_WINDOW_MS) * CLK_FREQ_HZ) / 1000;
    localparam int unsigned SYNC_STAGES     = 3;

endpackage : supervisor_pkg

// ==== verilog/input_sync.sv ====
// Three-stage synchroniser with agreement of the last two stages.
`timescale 1ns/100ps
module input_sync #(
    parameter logic RESET_VAL = 1'b1
) (
    input  wire logic clk_i,
    input  wire logic rstn_i,
    input  wire logic async_i,
    output logic      level_o
);
    logic [2:0] stage_reg;

    always_ff @(posedge clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            stage_reg <= {3{RESET_VAL}};
        end else begin
            stage_reg <= {stage_reg[1:0], async_i};
        end
    end

    // The level changes only once the second and third stages agree.
    always_ff @(posedge clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            level_o <= RESET_VAL;
        end else if (stage_reg[1] == stage_reg[2]) begin
            level_o <= stage_reg[2];
        end
    end

endmodule : input_sync

// ==== verilog/supervisor_reset_generator.sv ====
// Supervisory reset generator with watchdog and backup switchover.
//
// Summary of operation
// - Active-high style releases reset to its pull-up (high) on causes.
// - Active-low styles drive reset low on causes.
// - Reset stretched hold time after causes clear.
// - Watchdog expiry gives pulses, not a level.
// - Manual request low asserts reset, then 150ms.
// - Strobe idle past window triggers reset pulse.
// - Watchdog cleared by reset or strobe edges.
// - Auxiliary low asserts reset, 150ms after rising.
// - Supply below trip asserts, 150ms after recovery.
// - Switched supply from main, else greater source.
// - Backup switchover with hysteresis margins.
// - Backup flag cleared by main or main margin, else set by backup margin.
// - Build parameter picks reset polarity and drive.
`timescale 1ns/100ps
module supervisor_reset_generator
    import supervisor_pkg::*;
#(
    parameter reset_style_t RESET_STYLE = STYLE_LOW_PP,
    parameter longint unsigned HOLD_LEN = HOLD_CYCLES,
    parameter longint unsigned WD_LEN   = WD_CYCLES,
    parameter int unsigned CNT_W        = 32
) (
    input  wire logic                        clk_i,
    input  wire logic                        rstn_i,
    input  wire logic                        manual_request_n_i,
    input  wire logic                        activity_strobe_i,
    input  wire supervisor_pkg::supply_flags_t flags_i,
    output logic                             reset_pin_o,
    output logic                             reset_pin_oe_o,
    output logic                             backup_active_flag_o,
    output logic                             route_backup_o
);
    import supervisor_pkg::*;

    // Elaboration check: the counters must hold both lengths.
    localparam bit LEN_OK = CNT_W >= 1 && CNT_W <= 63 && HOLD_LEN >= 1
        && WD_LEN >= 2 && HOLD_LEN < (64'd1 << CNT_W)
        && WD_LEN < (64'd1 << CNT_W);
    if (!LEN_OK) begin : g_bad_len
        $error("Counter lengths do not fit the counter width.");
    end

    typedef enum logic [1:0] {
        ST_HOLD  = 2'b00,
        ST_RUN   = 2'b01,
        ST_PULSE = 2'b10
    } sup_state_t;

    ////////////////////////////////////////////////////////////////////////
    // Input synchronisation.

    logic manual_n;
    logic strobe;
    logic main_ok;
    logic aux_ok;
    logic backup_gt;
    logic main_gt;

    input_sync #(.RESET_VAL(1'b1)) u_sync_mr (
        .clk_i   (clk_i),
        .rstn_i  (rstn_i),
        .async_i (manual_request_n_i),
        .level_o (manual_n)
    );
    input_sync #(.RESET_VAL(1'b0)) u_sync_wd (
        .clk_i   (clk_i),
        .rstn_i  (rstn_i),
        .async_i (activity_strobe_i),
        .level_o (strobe)
    );
    input_sync #(.RESET_VAL(1'b0)) u_sync_main (
        .clk_i   (clk_i),
        .rstn_i  (rstn_i),
        .async_i (flags_i.main_ok),
        .level_o (main_ok)
    );
    input_sync #(.RESET_VAL(1'b0)) u_sync_aux (
        .clk_i   (clk_i),
        .rstn_i  (rstn_i),
        .async_i (flags_i.aux_ok),
        .level_o (aux_ok)
    );
    input_sync #(.RESET_VAL(1'b0)) u_sync_bgt (
        .clk_i   (clk_i),
        .rstn_i  (rstn_i),
        .async_i (flags_i.backup_gt_main),
        .level_o (backup_gt)
    );
    input_sync #(.RESET_VAL(1'b0)) u_sync_mgt (
        .clk_i   (clk_i),
        .rstn_i  (rstn_i),
        .async_i (flags_i.main_gt_backup),
        .level_o (main_gt)
    );

    ////////////////////////////////////////////////////////////////////////
    // Reset sequencing.

    logic             cause;
    logic             strobe_prev_reg;
    logic             strobe_edge;
    sup_state_t       state_reg;
    logic [CNT_W-1:0] hold_cnt_reg;
    logic [CNT_W-1:0] wd_cnt_reg;
    logic             assert_rst;

    // Manual request is assumed tied high when unused.
    assign cause = !main_ok || !manual_n || !aux_ok;
    assign strobe_edge = strobe ^ strobe_prev_reg;
    assign assert_rst = (state_reg != ST_RUN) || cause;

    always_ff @(posedge clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            strobe_prev_reg <= 1'b0;
        end else begin
            strobe_prev_reg <= strobe;
        end
    end

    // Hold stretching and watchdog pulse sequencing.
    always_ff @(posedge clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            state_reg    <= ST_HOLD;
            hold_cnt_reg <= '0;
        end else begin
            case (state_reg)
                ST_HOLD, ST_PULSE: begin
                    if (cause) begin
                        state_reg    <= ST_HOLD;
                        hold_cnt_reg <= '0;
                    end else if (hold_cnt_reg == CNT_W'(HOLD_LEN - 1)) begin
                        state_reg    <= ST_RUN;
                        hold_cnt_reg <= '0;
                    end else begin
                        hold_cnt_reg <= hold_cnt_reg + 1'b1;
                    end
                end
                ST_RUN: begin
                    hold_cnt_reg <= '0;
                    if (cause) begin
                        state_reg <= ST_HOLD;
                    end else if (wd_cnt_reg == CNT_W'(WD_LEN - 1)
                                 && !strobe_edge) begin
                        state_reg <= ST_PULSE;
                    end
                end
                default: begin
                    state_reg    <= ST_HOLD;
                    hold_cnt_reg <= '0;
                end
            endcase
        end
    end

    // Watchdog counter, held at zero while reset is asserted.
    always_ff @(posedge clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            wd_cnt_reg <= '0;
        end else if (assert_rst || strobe_edge) begin
            wd_cnt_reg <= '0;
        end else begin
            wd_cnt_reg <= wd_cnt_reg + 1'b1;
        end
    end

    // Output pin style and polarity.
    always_ff @(posedge clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            reset_pin_o    <= (RESET_STYLE == STYLE_HIGH_OD);
            reset_pin_oe_o <= (RESET_STYLE != STYLE_HIGH_OD);
        end else begin
            case (RESET_STYLE)
                STYLE_HIGH_OD: begin
                    reset_pin_o    <= assert_rst;
                    reset_pin_oe_o <= !assert_rst;
                end
                STYLE_LOW_OD: begin
                    reset_pin_o    <= 1'b0;
                    reset_pin_oe_o <= assert_rst;
                end
                default: begin
                    reset_pin_o    <= !assert_rst;
                    reset_pin_oe_o <= 1'b1;
                end
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Backup switchover.

    // Switched supply source, held between the two margins.
    always_ff @(posedge clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            route_backup_o <= 1'b0;
        end else if (main_ok) begin
            route_backup_o <= 1'b0;
        end else if (backup_gt) begin
            route_backup_o <= 1'b1;
        end else if (main_gt) begin
            route_backup_o <= 1'b0;
        end
    end

    always_ff @(posedge clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            backup_active_flag_o <= 1'b0;
        end else if (main_ok || main_gt) begin
            backup_active_flag_o <= 1'b0;
        end else if (backup_gt) begin
            backup_active_flag_o <= 1'b1;
        end
    end

endmodule : supervisor_reset_generator

// ==== verification/supervisor_reset_generator_properties.sv ====
// Port assertions for the supervisor reset generator.
`timescale 1ns/100ps
module supervisor_reset_generator_properties
    import supervisor_pkg::*;
#(
    parameter reset_style_t    RESET_STYLE = STYLE_LOW_PP,
    parameter longint unsigned HOLD_LEN    = 20,
    parameter longint unsigned WD_LEN      = 50
) (
    input wire logic                          clk_i,
    input wire logic                          rstn_i,
    input wire logic                          manual_request_n_i,
    input wire logic                          activity_strobe_i,
    input wire supervisor_pkg::supply_flags_t flags_i,
    input wire logic                          reset_pin_o,
    input wire logic                          reset_pin_oe_o,
    input wire logic                          backup_active_flag_o,
    input wire logic                          route_backup_o
);
    logic   asrt;
    longint quiet;
    longint idle;
    assign asrt = RESET_STYLE == STYLE_LOW_PP ? !reset_pin_o :
        reset_pin_oe_o ^ (RESET_STYLE == STYLE_HIGH_OD);
    // Cycles with no raw cause, and cycles out of reset with no strobe edge.
    always_ff @(posedge clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            quiet <= '0;
            idle <= '0;
        end else begin
            quiet <= flags_i.main_ok && flags_i.aux_ok &&
                manual_request_n_i ? quiet + 1 : '0;
            idle <= asrt || $changed(activity_strobe_i) ? '0 : idle + 1;
        end
    end
    default clocking dc @(posedge clk_i); endclocking
    default disable iff (!rstn_i);
    property p_sup; !flags_i.main_ok [*7] |-> asrt; endproperty
    a_sup: assert property (p_sup) else $error("supply low");
    property p_man; !manual_request_n_i [*7] |-> asrt; endproperty
    a_man: assert property (p_man) else $error("manual low");
    property p_aux; !flags_i.aux_ok [*7] |-> asrt; endproperty
    a_aux: assert property (p_aux) else $error("aux low");
    property p_hold; $fell(asrt) |-> quiet >= HOLD_LEN; endproperty
    a_hold: assert property (p_hold) else $error("short hold");
    property p_kick;
        $rose(asrt) && quiet > HOLD_LEN + 8 |-> idle >= WD_LEN - 1;
    endproperty
    a_kick: assert property (p_kick) else $error("early bite");
    property p_wd; idle >= WD_LEN + 8 |-> asrt; endproperty
    a_wd: assert property (p_wd) else $error("no bite");
    property p_bks; (!flags_i.main_ok && flags_i.backup_gt_main) [*7]
        |-> backup_active_flag_o && route_backup_o; endproperty
    a_bks: assert property (p_bks) else $error("no backup");
    property p_bkc; flags_i.main_gt_backup [*7]
        |-> !backup_active_flag_o && !route_backup_o; endproperty
    a_bkc: assert property (p_bkc) else $error("stuck backup");
endmodule : supervisor_reset_generator_properties

bind supervisor_reset_generator supervisor_reset_generator_properties
    #(.RESET_STYLE(RESET_STYLE), .HOLD_LEN(HOLD_LEN), .WD_LEN(WD_LEN))
    props_inst (.clk_i, .rstn_i, .manual_request_n_i, .activity_strobe_i,
    .flags_i, .reset_pin_o, .reset_pin_oe_o, .backup_active_flag_o,
    .route_backup_o);

// ==== verification/cpu_model.sv ====
// Processor model that toggles the activity strobe while out of reset.
`timescale 1ns/100ps
module cpu_model (
    input  wire logic clk_i,
    input  wire logic in_reset_i,
    input  wire logic kick_en_i,
    output logic      strobe_o
);
    logic [2:0] gap = 3'h0;
    logic       level_reg = 1'b0;
    assign strobe_o = level_reg;
    always @(posedge clk_i) begin
        gap <= in_reset_i || !kick_en_i ? 3'h0 : gap + 3'h1;
        if (gap == 3'h7) begin
            level_reg <= !level_reg;
        end
    end
endmodule : cpu_model

// ==== verification/supervisor_reset_generator_tb_top.sv ====
// Self-checking bench for the supervisor reset generator.
`timescale 1ns/100ps
module supervisor_reset_generator_tb_top;
    import supervisor_pkg::*;
    localparam int H = 20;
    localparam int W = 50;
    logic clk_i = 1'b0, rstn_i = 1'b0, mreq_n = 1'b1, kick = 1'b1;
    logic strobe, pin, oe, bk, rt;
    wire [1:0] od_pin, od_oe;
    supply_flags_t flags = 4'hc;
    int mismatches = 0, check_count = 0, n;
    always #5 clk_i = !clk_i;
    supervisor_reset_generator #(.HOLD_LEN(H), .WD_LEN(W))
        supervisor_reset_generator_inst (.clk_i, .rstn_i,
        .manual_request_n_i(mreq_n), .activity_strobe_i(strobe),
        .flags_i(flags), .reset_pin_o(pin), .reset_pin_oe_o(oe),
        .backup_active_flag_o(bk), .route_backup_o(rt));
    // Open-drain styles share the inputs: 0 active high, 1 active low.
    for (genvar s = 0; s < 2; s++) begin : g_od
        supervisor_reset_generator #(.HOLD_LEN(H), .WD_LEN(W),
            .RESET_STYLE(s == 0 ? STYLE_HIGH_OD : STYLE_LOW_OD))
            supervisor_reset_generator_inst (.clk_i, .rstn_i,
            .manual_request_n_i(mreq_n), .activity_strobe_i(strobe),
            .flags_i(flags), .reset_pin_o(od_pin[s]),
            .reset_pin_oe_o(od_oe[s]), .backup_active_flag_o(),
            .route_backup_o());
    end
    cpu_model cpu_model_inst (.clk_i, .in_reset_i(!pin), .kick_en_i(kick),
        .strobe_o(strobe));
    task automatic check(input logic [31:0] seen, exp);
        check_count++;
        if (seen !== exp) begin
            mismatches++;
            $display("CHECK FAILED at %0t: got %0h", $time, seen);
        end
    endtask : check
    // Pin levels of all three styles, open-drain pins with a pull-up.
    task automatic check_pin(input logic asserted);
        check(pin, !asserted);
        check(oe, 1'b1);
        check(od_oe[0] ? od_pin[0] : 1'b1, asserted);
        check(od_oe[1] ? od_pin[1] : 1'b1, !asserted);
    endtask : check_pin
    task automatic give_verdict;
        $display("checks %0d mismatches %0d", check_count, mismatches);
        if (mismatches == 0 && check_count > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask : give_verdict
    task automatic await(input logic lvl, input int lim);
        for (n = 0; pin !== !lvl && n < lim; n++) @(negedge clk_i);
        if (n == lim) begin
            mismatches++;
            give_verdict();
        end
    endtask : await
    task automatic t_causes;
        for (int k = 0; k < 3; k++) begin
            @(posedge clk_i);
            mreq_n <= k != 1;
            flags <= k == 0 ? 4'h4 : k == 2 ? 4'h8 : 4'hc;
            await(1, 12);
            repeat (40) @(negedge clk_i);
            check_pin(1'b1);
            @(posedge clk_i);
            mreq_n <= 1'b1;
            flags <= 4'hc;
            await(0, H + 20);
            check(n >= H, 1'b1);
        end
        $display("cause test done");
    endtask : t_causes
    task automatic t_watchdog;
        @(posedge clk_i);
        kick <= 1'b0;
        await(1, W + 20);
        await(0, H + 8);
        check(n + 2 >= H && n <= H + 2, 1'b1);
        await(1, W + 8);
        check(n + 2 >= W, 1'b1);
        await(0, H + 8);
        @(posedge clk_i);
        kick <= 1'b1;
        repeat (3 * W) begin
            @(negedge clk_i);
            check_pin(1'b0);
        end
        $display("watchdog test done");
    endtask : t_watchdog
    task automatic t_backup;
        supply_flags_t v[4] = '{4'he, 4'h6, 4'h4, 4'h5};
        logic [1:0] e[4] = '{2'h0, 2'h3, 2'h3, 2'h0};
        for (int k = 0; k < 4; k++) begin
            @(posedge clk_i);
            flags <= v[k];
            repeat (10) @(negedge clk_i);
            check({bk, rt}, e[k]);
            check_pin(!v[k].main_ok);
        end
        @(posedge clk_i);
        flags <= 4'hc;
        await(0, H + 20);
        $display("backup test done");
    endtask : t_backup
    initial begin
        repeat (12) @(posedge clk_i);
        rstn_i <= 1'b1;
        await(0, H + 30);
        t_causes();
        t_watchdog();
        t_backup();
        give_verdict();
    end
endmodule : supervisor_reset_generator_tb_top
